// >>> hdl/hvw_pkg.sv
// constants shared by the high-voltage wake input block
`default_nettype none

package hvw_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned WAKE_FILTER_TIME_US = 16;
  // least time, so round up to whole cycles, never below one
  localparam int unsigned WAKE_FILTER_CYC_RAW =
    (WAKE_FILTER_TIME_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned WAKE_FILTER_CYC =
    (WAKE_FILTER_CYC_RAW < 1) ? 1 : WAKE_FILTER_CYC_RAW;
  localparam int unsigned FILT_CNT_W = 8;

  // ------------------------------------------------------------------
  // register map (byte addresses on the wishbone bus)
  // ------------------------------------------------------------------
  localparam int unsigned ADR_W = 4;
  localparam logic [3:0] OFS_HARDWARE_CONTROL_REG = 4'h0;
  localparam logic [3:0] OFS_LVL_STAT = 4'h4;
  localparam logic [3:0] OFS_WAKE_STAT1 = 4'h8;
  localparam logic [3:0] OFS_PUPD_CTRL = 4'hC;

  // ------------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------------
  localparam int unsigned HWC_BUCK_SEL_BIT = 0;
  localparam int unsigned HWC_WAKE_EN_BIT = 1;
  localparam int unsigned HWC_CYCLIC_BIT = 2;
  localparam int unsigned HWC_W = 3;
  localparam logic [2:0] HWC_RST = 3'h0;
  localparam int unsigned LVL_BIT = 0;
  localparam int unsigned WU_FLAG_BIT = 0;
  localparam int unsigned PUPD_LOW_BIT = 0;
  localparam int unsigned PUPD_HIGH_BIT = 1;
  localparam logic [1:0] PUPD_RST = 2'h0;

  // ------------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------------
  localparam logic [1:0] PUPD_NONE = 2'h0;
  localparam logic [1:0] PUPD_DOWN = 2'h1;
  localparam logic [1:0] PUPD_UP = 2'h2;
  localparam logic [1:0] PUPD_AUTO = 2'h3;

  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_STOP = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [1:0] MODE_FAILSAFE = 2'h3;

endpackage

`default_nettype wire

// >>> hdl/hvw_filter.sv
// pin synchroniser and wake deglitch filter
`timescale 1ns/100ps
`default_nettype none

module hvw_filter #(
  parameter int unsigned CNT_W = hvw_pkg::FILT_CNT_W,
  parameter int unsigned FILT_CYC = hvw_pkg::WAKE_FILTER_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // pin side
  input wire logic pin_async,
  input wire logic active,
  // raw and filtered results
  output logic raw_level,
  output logic filt_level,
  output logic edge_pulse
);

  logic s1_r, s2_r, s3_r;
  logic raw_r;
  logic filt_r;
  logic edge_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FILT_CYC - 1);

  // a level counts once the second and third stages agree
  wire agree = (s2_r == s3_r);
  wire differs = agree && (s3_r != filt_r);
  wire counting = active && differs;
  wire done = counting && (cnt_r == CNT_LAST);
  assign cnt_nxt = (counting && !done) ? cnt_r + CNT_W'(1) : '0;

  // three-stage synchroniser; only s2 reads s1
  always_ff @(posedge clk_sys)
  begin
    s1_r <= pin_async;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // raw level skips the deglitch filter, used for buck steering
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      raw_r <= 1'b0;
    else if (agree)
      raw_r <= s3_r;
  end

  // any disagreement or return to old level restarts the count
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      cnt_r <= '0;
      filt_r <= 1'b0;
      edge_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      edge_r <= done;
      if (done)
        filt_r <= s3_r;
    end
  end

  assign raw_level = raw_r;
  assign filt_level = filt_r;
  assign edge_pulse = edge_r;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_filt_needs_stable;
    @(posedge clk_sys) disable iff (!rstn)
    (filt_r != $past(filt_r)) |-> ($past(cnt_r) == CNT_LAST) && $past(counting);
  endproperty
  a_filt_needs_stable: assert property (p_filt_needs_stable)
    else $error("filtered level changed before the filter time");

  property p_edge_both_ways;
    @(posedge clk_sys) disable iff (!rstn)
    $changed(filt_r) |-> edge_r;
  endproperty
  a_edge_both_ways: assert property (p_edge_both_ways)
    else $error("level change without edge pulse");

  property p_inactive_no_edge;
    @(posedge clk_sys) disable iff (!rstn)
    !active |=> !edge_r && $stable(filt_r);
  endproperty
  a_inactive_no_edge: assert property (p_inactive_no_edge)
    else $error("edge seen outside the sense window");

endmodule

`default_nettype wire

// >>> hdl/hvw_top.sv
// high-voltage wake input: edge events, buck steering, pin current sources
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none


module hvw_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [hvw_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // chip context
  input wire logic [1:0] power_mode,
  input wire logic cyclic_window,
  // pin comparator output, asynchronous
  input wire logic wake_pin_cmp,
  // event requests, one-cycle pulses
  output logic wake_irq_req,
  output logic wake_up_req,
  output logic restart_req,
  // buck converter steering
  output logic buck_pin_ctrl_active,
  output logic buck_pwm_sel,
  // pin current sources
  output logic pull_up_en,
  output logic pull_down_en
);

  // ------------------------------------------------------------------
  // registers and wires
  // ------------------------------------------------------------------
  logic [hvw_pkg::HWC_W-1:0] hardware_control_reg_r;
  logic [1:0] pin_current_source_ctrl_reg_r;
  logic pin_wake_source_flag_r;
  logic wake_pin_level_bit_r;
  logic wb_ack_r;
  logic [31:0] wb_dat_r;
  logic irq_r, wake_r, restart_r;
  logic buck_act_r, buck_pwm_r;
  logic pu_r, pd_r;
  logic raw_level;
  logic filt_level;
  logic pin_edge;

  // ------------------------------------------------------------------
  // control field decode
  // ------------------------------------------------------------------
  wire buck_mode_from_pin_select = hardware_control_reg_r[hvw_pkg::HWC_BUCK_SEL_BIT];
  wire wake_pin_capability_enable = hardware_control_reg_r[hvw_pkg::HWC_WAKE_EN_BIT];
  wire cyclic_sense_sel = hardware_control_reg_r[hvw_pkg::HWC_CYCLIC_BIT];
  wire current_select_bit_low = pin_current_source_ctrl_reg_r[hvw_pkg::PUPD_LOW_BIT];
  wire current_select_bit_high = pin_current_source_ctrl_reg_r[hvw_pkg::PUPD_HIGH_BIT];

  // power mode decode
  wire mode_normal = (power_mode == hvw_pkg::MODE_NORMAL);
  wire mode_stop = (power_mode == hvw_pkg::MODE_STOP);
  wire mode_sleep = (power_mode == hvw_pkg::MODE_SLEEP);
  wire mode_failsafe = (power_mode == hvw_pkg::MODE_FAILSAFE);
  wire mode_awake = mode_normal || mode_stop;

  // static sense watches always, cyclic only inside the window
  wire monitor_active = !cyclic_sense_sel || cyclic_window;

  // ------------------------------------------------------------------
  // synchroniser and deglitch filter
  // ------------------------------------------------------------------
  hvw_filter #(
    .CNT_W(hvw_pkg::FILT_CNT_W),
    .FILT_CYC(hvw_pkg::WAKE_FILTER_CYC)
  ) u_filter (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin_async(wake_pin_cmp),
    .active(monitor_active),
    .raw_level(raw_level),
    .filt_level(filt_level),
    .edge_pulse(pin_edge)
  );

  // ------------------------------------------------------------------
  // wake event routing
  // ------------------------------------------------------------------
  // fail-safe ignores the enable bit: a stuck system must always restart
  wire ev_irq = pin_edge && wake_pin_capability_enable && mode_awake;
  wire ev_wake = pin_edge && wake_pin_capability_enable && mode_sleep;
  wire ev_restart = pin_edge && mode_failsafe;
  wire ev_flag = ev_irq || ev_wake || ev_restart;

  // request pulses, one cycle each
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      irq_r <= 1'b0;
      wake_r <= 1'b0;
      restart_r <= 1'b0;
    end
    else
    begin
      irq_r <= ev_irq;
      wake_r <= ev_wake;
      restart_r <= ev_restart;
    end
  end

  // ------------------------------------------------------------------
  // wishbone decode
  // ------------------------------------------------------------------
  // one wait state: ack the cycle after the request, then drop it
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_r;
  wire wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  wire hit_hwc = (wb_adr_i == hvw_pkg::OFS_HARDWARE_CONTROL_REG);
  wire hit_lvl = (wb_adr_i == hvw_pkg::OFS_LVL_STAT);
  wire hit_stat = (wb_adr_i == hvw_pkg::OFS_WAKE_STAT1);
  wire hit_pupd = (wb_adr_i == hvw_pkg::OFS_PUPD_CTRL);
  wire wr_hwc = wb_wr && hit_hwc;
  wire wr_pupd = wb_wr && hit_pupd;
  // write one to clear; a clear in the same cycle as a new event loses
  wire clr_flag = wb_wr && hit_stat && wb_dat_i[hvw_pkg::WU_FLAG_BIT];

  // read mux; unmapped offsets read as zero and are still acknowledged
  wire [31:0] rd_hwc = {{(32-hvw_pkg::HWC_W){1'b0}}, hardware_control_reg_r};
  wire [31:0] rd_lvl = {31'h0, wake_pin_level_bit_r};
  wire [31:0] rd_stat = {31'h0, pin_wake_source_flag_r};
  wire [31:0] rd_pupd = {30'h0, pin_current_source_ctrl_reg_r};
  wire [31:0] rd_mux = hit_hwc ? rd_hwc :
                       hit_lvl ? rd_lvl :
                       hit_stat ? rd_stat :
                       hit_pupd ? rd_pupd : 32'h0;

  // bus handshake and read data
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      wb_ack_r <= 1'b0;
      wb_dat_r <= 32'h0;
    end
    else
    begin
      wb_ack_r <= wb_req;
      if (wb_req && !wb_we_i)
        wb_dat_r <= rd_mux;
    end
  end

  // ------------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------------
  // only byte lane 0 carries fields, so only sel[0] matters
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      hardware_control_reg_r <= hvw_pkg::HWC_RST;
      pin_current_source_ctrl_reg_r <= hvw_pkg::PUPD_RST;
    end
    else
    begin
      if (wr_hwc)
        hardware_control_reg_r <= wb_dat_i[hvw_pkg::HWC_W-1:0];
      if (wr_pupd)
        pin_current_source_ctrl_reg_r <= wb_dat_i[1:0];
    end
  end

  // ------------------------------------------------------------------
  // status registers
  // ------------------------------------------------------------------
  // sticky source flag; set wins over a simultaneous clear
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      pin_wake_source_flag_r <= 1'b0;
    else if (ev_flag)
      pin_wake_source_flag_r <= 1'b1;
    else if (clr_flag)
      pin_wake_source_flag_r <= 1'b0;
  end

  // level is tracked only while awake; it holds its last value otherwise
  // and feeds no event logic at all
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      wake_pin_level_bit_r <= 1'b0;
    else if (mode_awake)
      wake_pin_level_bit_r <= filt_level;
  end

  // ------------------------------------------------------------------
  // buck modulation steering
  // ------------------------------------------------------------------
  // the controller drives the pin cleanly here, so the filter is skipped
  wire buck_steer = buck_mode_from_pin_select && mode_stop;

  // outside steering the buck stays in PWM, the safe default for load
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      buck_act_r <= 1'b0;
      buck_pwm_r <= 1'b1;
    end
    else
    begin
      buck_act_r <= buck_steer;
      if (buck_steer)
        buck_pwm_r <= raw_level;
      else
        buck_pwm_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // pin current sources
  // ------------------------------------------------------------------
  // automatic mode follows the filtered level so a glitch cannot flip it
  wire sel_auto = current_select_bit_high && current_select_bit_low;
  wire pu_nxt = (current_select_bit_high && !current_select_bit_low) ||
                (sel_auto && filt_level);
  wire pd_nxt = (!current_select_bit_high && current_select_bit_low) ||
                (sel_auto && !filt_level);

  // never both on; the decode above keeps them exclusive
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      pu_r <= 1'b0;
      pd_r <= 1'b0;
    end
    else
    begin
      pu_r <= pu_nxt;
      pd_r <= pd_nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = wb_dat_r;
  assign wake_irq_req = irq_r;
  assign wake_up_req = wake_r;
  assign restart_req = restart_r;
  assign buck_pin_ctrl_active = buck_act_r;
  assign buck_pwm_sel = buck_pwm_r;
  assign pull_up_en = pu_r;
  assign pull_down_en = pd_r;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence s_edge_awake_en;
    pin_edge && wake_pin_capability_enable && mode_awake;
  endsequence

  sequence s_irq_only;
    wake_irq_req && !wake_up_req && !restart_req;
  endsequence

  property p_irq_awake;
    @(posedge clk_sys) disable iff (!rstn)
    s_edge_awake_en |=> s_irq_only ##1 !wake_irq_req;
  endproperty
  a_irq_awake: assert property (p_irq_awake)
    else $error("awake edge did not give a single interrupt pulse");

  property p_wake_sleep;
    @(posedge clk_sys) disable iff (!rstn)
    pin_edge && wake_pin_capability_enable && mode_sleep
      |=> wake_up_req && !wake_irq_req;
  endproperty
  a_wake_sleep: assert property (p_wake_sleep)
    else $error("sleep edge did not request wake-up");

  property p_restart_fs;
    @(posedge clk_sys) disable iff (!rstn)
    pin_edge && mode_failsafe |=> restart_req && !wake_up_req && !wake_irq_req;
  endproperty
  a_restart_fs: assert property (p_restart_fs)
    else $error("fail-safe edge did not request restart");

  property p_disabled_quiet;
    @(posedge clk_sys) disable iff (!rstn)
    !(pin_edge && (wake_pin_capability_enable || mode_failsafe))
      |=> !wake_irq_req && !wake_up_req;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("request without an enabled edge");

  property p_buck_pfm;
    @(posedge clk_sys) disable iff (!rstn)
    buck_steer && !raw_level |=> buck_pin_ctrl_active && !buck_pwm_sel;
  endproperty
  a_buck_pfm: assert property (p_buck_pfm)
    else $error("low pin did not select pfm");

  property p_buck_pwm;
    @(posedge clk_sys) disable iff (!rstn)
    buck_steer && raw_level |=> buck_pin_ctrl_active && buck_pwm_sel;
  endproperty
  a_buck_pwm: assert property (p_buck_pwm)
    else $error("high pin did not select pwm");

  property p_flag_sticky;
    @(posedge clk_sys) disable iff (!rstn)
    pin_wake_source_flag_r && !clr_flag |=> pin_wake_source_flag_r;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("wake flag cleared without software");

  property p_flag_set;
    @(posedge clk_sys) disable iff (!rstn)
    ev_flag |=> pin_wake_source_flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("wake event did not set the source flag");

  property p_level_stat;
    @(posedge clk_sys) disable iff (!rstn)
    mode_awake |=> wake_pin_level_bit_r == $past(filt_level);
  endproperty
  a_level_stat: assert property (p_level_stat)
    else $error("level status does not follow the pin");

  property p_auto_pull;
    @(posedge clk_sys) disable iff (!rstn)
    sel_auto |=> pull_up_en == $past(filt_level) && pull_down_en == !$past(filt_level);
  endproperty
  a_auto_pull: assert property (p_auto_pull)
    else $error("automatic current source picked the wrong side");

  property p_fixed_pull;
    @(posedge clk_sys) disable iff (!rstn)
    pin_current_source_ctrl_reg_r == hvw_pkg::PUPD_NONE |=> !pull_up_en && !pull_down_en;
  endproperty
  a_fixed_pull: assert property (p_fixed_pull)
    else $error("current source on with selection none");

  // static sense must keep counting a settled difference whatever the window does
  property p_static_always;
    @(posedge clk_sys) disable iff (!rstn)
    !cyclic_sense_sel && u_filter.differs |=> (u_filter.cnt_r != '0) || pin_edge;
  endproperty
  a_static_always: assert property (p_static_always)
    else $error("static sense dropped a pending level change");

endmodule

`default_nettype wire

// >>> hdl/hvw_dummy_never.sv
// holds no logic; the block is hvw_top with its hvw_filter

// >>> tb/hvw_pin_model.sv
// partner model: switch or signal on the wake pin
`timescale 1ns/100ps
`default_nettype none

module hvw_pin_model (
  // pacing clock
  input wire logic clk_sys,
  // comparator output seen by the block
  output logic pin
);
  // starts low so reset never meets a pending edge
  initial pin = 1'b0;

  // level lands after an edge; the block syncs it anyway
  task automatic set_level(input logic lvl);
    @(posedge clk_sys);
    pin <= lvl;
  endtask
endmodule

`default_nettype wire

// >>> tb/hvw_top_test.sv
// self-checking bench for the wake input block
`timescale 1ns/100ps
`default_nettype none

module hvw_top_test;
  // ----------
  // signals
  // ----------
  typedef struct packed {logic [1:0] mode; logic en; logic [2:0] ev;} hvw_row_s;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [3:0] lane = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, wake_pin_cmp, wake_irq_req, wake_up_req, restart_req;
  logic [1:0] power_mode = 2'h0;
  logic cyclic_window = 1'b0;
  logic buck_pin_ctrl_active, buck_pwm_sel, pull_up_en, pull_down_en;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  logic lvl = 1'b0;
  logic [2:0] ev;
  logic [31:0] rd;
  // {irq, wake, restart} expected per mode and enable
  hvw_row_s rows [7] = '{'{2'h0, 1'b1, 3'h4}, '{2'h1, 1'b1, 3'h4}, '{2'h2, 1'b1, 3'h2},
    '{2'h3, 1'b0, 3'h1}, '{2'h0, 1'b0, 3'h0}, '{2'h2, 1'b0, 3'h0}, '{2'h3, 1'b1, 3'h1}};

  hvw_top dut_u (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .power_mode(power_mode),
    .cyclic_window(cyclic_window), .wake_pin_cmp(wake_pin_cmp),
    .wake_irq_req(wake_irq_req), .wake_up_req(wake_up_req), .restart_req(restart_req),
    .buck_pin_ctrl_active(buck_pin_ctrl_active), .buck_pwm_sel(buck_pwm_sel),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en));
  hvw_pin_model pin_u (.clk_sys(clk_sys), .pin(wake_pin_cmp));

  // 10 MHz clock
  always #50 clk_sys = ~clk_sys;

  // hang guard, well above the few thousand cycles the tests need
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fail_count++;
      stop_test();
    end
  end

  // ----------
  // tasks
  // ----------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // classic cycle; request held until ack is sampled high at a rising edge
  task automatic wb_xfer(input logic we, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= lane;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_sys);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    // the slave must drop ack in the cycle after it gave it
    @(posedge clk_sys);
    chk("ack drop", 32'h0, {31'h0, wb_ack_o});
  endtask

  // gathers request pulses over a window
  task automatic wait_ev(input int unsigned cyc);
    ev = 3'h0;
    repeat (cyc)
    begin
      @(negedge clk_sys);
      ev = ev | {wake_irq_req, wake_up_req, restart_req};
    end
  endtask

  task automatic flip();
    lvl = ~lvl;
    pin_u.set_level(lvl);
  endtask

  task automatic stop_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------
  // sequence
  // ----------
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int a = 0; a < 5; a++)
    begin
      wb_xfer(1'b0, (a == 4) ? 4'h2 : 4'(a * 4), 32'h0);
      chk("reg reset", 32'h0, rd);
    end
    chk("outs reset", 32'h1, {29'h0, pull_up_en, pull_down_en, buck_pwm_sel});
    $display("end reset test");
    // mode and enable table; pin alternates, so both edge directions occur
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clk_sys);
      power_mode <= rows[i].mode;
      wb_xfer(1'b1, hvw_pkg::OFS_HARDWARE_CONTROL_REG, {30'h0, rows[i].en, 1'b0});
      flip();
      wait_ev(250);
      chk("event", {29'h0, rows[i].ev}, {29'h0, ev});
      wb_xfer(1'b0, hvw_pkg::OFS_WAKE_STAT1, 32'h0);
      chk("flag", {31'h0, rows[i].ev != 3'h0}, rd);
      wb_xfer(1'b1, hvw_pkg::OFS_WAKE_STAT1, 32'h1);
      wb_xfer(1'b0, hvw_pkg::OFS_WAKE_STAT1, 32'h0);
      chk("flag clear", 32'h0, rd);
      wb_xfer(1'b0, hvw_pkg::OFS_LVL_STAT, 32'h0);
      if (rows[i].mode < hvw_pkg::MODE_SLEEP)
        chk("level", {31'h0, lvl}, rd);
      $display("end row %0d", i);
    end
    // short glitch is dropped; a real change needs the full filter time
    @(posedge clk_sys);
    power_mode <= hvw_pkg::MODE_NORMAL;
    pin_u.set_level(~lvl);
    repeat (150) @(posedge clk_sys);
    pin_u.set_level(lvl);
    wait_ev(250);
    chk("glitch", 32'h0, {29'h0, ev});
    flip();
    wait_ev(155);
    chk("early", 32'h0, {29'h0, ev});
    wait_ev(100);
    chk("filtered", 32'h4, {29'h0, ev});
    $display("end filter test");
    // cyclic sense: nothing outside the window
    wb_xfer(1'b1, hvw_pkg::OFS_HARDWARE_CONTROL_REG, 32'h6);
    flip();
    wait_ev(250);
    chk("no window", 32'h0, {29'h0, ev});
    @(posedge clk_sys);
    cyclic_window <= 1'b1;
    wait_ev(250);
    chk("in window", 32'h4, {29'h0, ev});
    $display("end cyclic test");
    // current sources, auto follows the filtered level
    for (int s = 0; s < 4; s++)
    begin
      wb_xfer(1'b1, hvw_pkg::OFS_PUPD_CTRL, 32'(s));
      wb_xfer(1'b0, hvw_pkg::OFS_PUPD_CTRL, 32'h0);
      chk("select", 32'(s), rd);
      chk("pull", {30'h0, s == 2 || (s == 3 && lvl), s == 1 || (s == 3 && !lvl)},
        {30'h0, pull_up_en, pull_down_en});
    end
    flip();
    wait_ev(250);
    chk("pull auto", {30'h0, lvl, !lvl}, {30'h0, pull_up_en, pull_down_en});
    $display("end current test");
    // buck steering reacts far faster than the filter
    wb_xfer(1'b1, hvw_pkg::OFS_HARDWARE_CONTROL_REG, 32'h1);
    @(posedge clk_sys);
    power_mode <= hvw_pkg::MODE_STOP;
    repeat (2)
    begin
      flip();
      repeat (8) @(negedge clk_sys);
      chk("buck", {30'h0, 1'b1, lvl}, {30'h0, buck_pin_ctrl_active, buck_pwm_sel});
    end
    @(posedge clk_sys);
    power_mode <= hvw_pkg::MODE_NORMAL;
    repeat (3) @(negedge clk_sys);
    chk("buck off", 32'h1, {30'h0, buck_pin_ctrl_active, buck_pwm_sel});
    $display("end buck test");
    // reset in mid-run clears the control registers
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    wb_xfer(1'b0, hvw_pkg::OFS_HARDWARE_CONTROL_REG, 32'h0);
    chk("ctrl rerst", 32'h0, rd);
    chk("outs rerst", 32'h1, {29'h0, pull_up_en, pull_down_en, buck_pwm_sel});
    // a write without byte lane 0 is acknowledged but changes nothing
    lane = 4'hE;
    wb_xfer(1'b1, hvw_pkg::OFS_HARDWARE_CONTROL_REG, 32'h7);
    lane = 4'hF;
    wb_xfer(1'b0, hvw_pkg::OFS_HARDWARE_CONTROL_REG, 32'h0);
    chk("lane ignored", 32'h0, rd);
    $display("end rereset test");
    stop_test();
  end
endmodule

`default_nettype wire
